// ### src/tcwave_regs.vh
/*
  register offsets, field positions, reset values and command codes of the
  timer compare and waveform unit.
  assumes: included by the unit's design file only; no process lives here.
*/
`ifndef TCWAVE_REGS_VH
`define TCWAVE_REGS_VH

// byte offsets on the apb bus
`define OFF_CLKCTRL    12'h000
`define OFF_MODECTRL   12'h004
`define OFF_FORCECTRL  12'h008
`define OFF_CMDCTRL    12'h00c
`define OFF_FLAGS      12'h010
`define OFF_INVCTRL    12'h014
`define OFF_COUNTER    12'h020
`define OFF_PERIOD     12'h024
`define OFF_PERIOD_BUFFER     12'h028
`define OFF_CMP0       12'h030
`define OFF_CMPBUF0    12'h040

// reset values
`define RST_CLKCTRL    4'h0
`define RST_MODECTRL   8'h00
`define RST_FORCECTRL  4'h0
`define RST_PERIOD     16'hffff

// clock source codes
`define CLK_OFF        4'h0

// waveform modes
`define WM_NORMAL      3'h0
`define WM_FREQ        3'h1
`define WM_SINGLE      3'h3
`define WM_DSTOP       3'h5
`define WM_DSBOTH      3'h6
`define WM_DSBOTTOM    3'h7

// field positions
`define MODE_EN_LSB    4
`define CMD_UPDATE     0
`define CMD_RESTART    1
`define CMD_RESET      2
`define CMD_LOCK       3
`define FLAG_OVF       0
`define FLAG_ERR       1
`define FLAG_CH_LSB    4

`endif

// ### src/timer_compare_waveform_unit.v
/*
  16-bit timer counter with four compare channels, prescaler, double
  buffered period and compare values, waveform generation and port override.
  assumes: single pclk domain; event inputs and dma strobes are synchronous to
  pclk; apb master keeps to the standard two phase protocol.
*/
// How it works
// - each channel compares counter with its compare value every timer clock tick.
// - match sets channel flag one tick later and pulses the channel event.
// - buffered compare values load at the mode's update point or on an update command.
// - enabled channel in a waveform mode replaces the port output latch unless its event action is on.
// - pin invert enable drives the inverted waveform onto the pin.
// - frequency mode uses channel a value as top, toggling on each match.
// - frequency mode, no prescale, value zero toggles every peripheral clock.
// - single slope counts bottom to period then restarts, period plus one ticks.
// - single slope output set on compare match, cleared at top.
// - period value sets pwm resolution, from two up to full sixteen bits.
// - dual slope counts up to top, then down to bottom, repeatedly.
// - dual slope output set at bottom, cleared matching up, set matching down.
// - overflow/underflow flag, per channel match flags and capture error flag exist.
// - every flag-raising condition also pulses an event output.
// - overflow flag is a dma request, cleared by dma write to counter or period.
// - channel flag is a dma request, cleared by dma access to its buffer.
// - update command acts like natural update, ignored while lock is set.
// - restart command clears counter, direction and compare outputs at once.
// - reset command restores all registers, accepted only with clock off.
// - clock source: off, prescale 1..1024, or event channel n.
// - mode codes normal, freq, single, three dual slopes; others reserved.
// - with timer off, forced output bits set each channel's waveform output.
`timescale 1ns/1ps
`include "tcwave_regs.vh"

module timer_compare_waveform_unit (
  // apb slave
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // event system
  input  wire [7:0]  event_in,
  output wire        ovf_event,
  output wire [3:0]  match_event,
  // dma
  input  wire        dma_ack_ovf,
  input  wire [3:0]  dma_ack_ch,
  output wire        dma_req_ovf,
  output wire [3:0]  dma_req_ch,
  // port
  input  wire [3:0]  port_out_latch,
  input  wire [3:0]  event_action_on,
  output reg  [3:0]  pin_out
);

  // registers
  reg  [3:0]  clock_source_select_r;
  reg  [2:0]  waveform_mode_select_r;
  reg  [3:0]  channel_output_enable_r;
  reg  [3:0]  forced_output_value_r;
  reg  [3:0]  pin_invert_enable_r;
  reg         lock_update_r;
  reg  [15:0] counter_value_r;
  reg  [15:0] period_value_r;
  reg  [15:0] period_buffer_r;
  reg  [15:0] channel_compare_value_r  [0:3];
  reg  [15:0] channel_compare_buffer_r [0:3];
  reg  [3:0]  waveform_output_r;
  reg         down_r;
  reg  [3:0]  channel_match_flag_r;
  reg         overflow_underflow_flag_r;
  reg         capture_error_flag_r;
  reg  [9:0]  prescale_r;
  reg  [7:0]  event_d_r;
  reg  [3:0]  match_pend_r;
  reg         ovf_pend_r;

  wire        wr_en;
  wire        rd_en;
  wire        tick;
  wire        timer_on;
  wire        dual;
  wire [15:0] top;
  wire        at_top;
  wire        at_bottom;
  wire        upd_natural;
  wire        upd_cmd;
  wire        do_update;
  wire        restart_cmd;
  wire        reset_cmd;
  wire        ovf_cond;
  wire [3:0]  match;

  //////////////////////////////////////////////////////////////////////////
  // apb decode: zero wait states, no error response
  assign pready  = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;

  // prescaler tap select, shared by tick generation
  function prescale_hit;
    input [3:0] sel;
    input [9:0] cnt;
    begin
      case (sel[2:0])
        3'h1:    prescale_hit = 1'b1;
        3'h2:    prescale_hit = cnt[0];
        3'h3:    prescale_hit = &cnt[1:0];
        3'h4:    prescale_hit = &cnt[2:0];
        3'h5:    prescale_hit = &cnt[5:0];
        3'h6:    prescale_hit = &cnt[7:0];
        3'h7:    prescale_hit = &cnt[9:0];
        default: prescale_hit = 1'b0;
      endcase
    end
  endfunction

  //////////////////////////////////////////////////////////////////////////
  // timer clock: prescaled pclk or a rising event edge
  assign timer_on = clock_source_select_r != `CLK_OFF;
  assign tick = clock_source_select_r[3] ?
                (event_in[clock_source_select_r[2:0]] & ~event_d_r[clock_source_select_r[2:0]]) :
                prescale_hit(clock_source_select_r, prescale_r);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prescale_r <= 10'h000;
      event_d_r  <= 8'h00;
    end else begin
      event_d_r  <= event_in;
      prescale_r <= timer_on ? prescale_r + 10'h001 : 10'h000;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // mode decode; reserved codes behave as normal mode but still enable the pin override
  assign dual      = waveform_mode_select_r[2] & (waveform_mode_select_r[1] | waveform_mode_select_r[0]);
  assign top       = (waveform_mode_select_r == `WM_FREQ) ? channel_compare_value_r[0] : period_value_r;
  assign at_top    = counter_value_r == top;
  assign at_bottom = counter_value_r == 16'h0000;
  assign upd_natural = tick & ((waveform_mode_select_r == `WM_SINGLE || dual) ? (at_bottom & down_r | 
                       at_bottom & ~dual) : at_top);
  assign upd_cmd     = wr_en && paddr == `OFF_CMDCTRL && pwdata[`CMD_UPDATE] && !lock_update_r;
  assign do_update   = upd_natural | upd_cmd;
  assign restart_cmd = wr_en && paddr == `OFF_CMDCTRL && pwdata[`CMD_RESTART];
  assign reset_cmd   = wr_en && paddr == `OFF_CMDCTRL && pwdata[`CMD_RESET] && !timer_on;

  // overflow condition per mode
  assign ovf_cond = tick & (
    (waveform_mode_select_r == `WM_SINGLE)   ? at_top :
    (waveform_mode_select_r == `WM_DSTOP)    ? at_top & ~down_r :
    (waveform_mode_select_r == `WM_DSBOTH)   ? (at_top & ~down_r) | (at_bottom & down_r) :
    (waveform_mode_select_r == `WM_DSBOTTOM) ? at_bottom & down_r : at_top);

  //////////////////////////////////////////////////////////////////////////
  // counter and direction
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      counter_value_r <= 16'h0000;
      down_r          <= 1'b0;
    end else if (reset_cmd || restart_cmd) begin
      counter_value_r <= 16'h0000;
      down_r          <= 1'b0;
    end else if (wr_en && paddr == `OFF_COUNTER) begin
      counter_value_r <= pwdata[15:0];   // bus write beats counting
    end else if (tick) begin
      if (dual) begin
        if (!down_r && at_top) begin
          down_r          <= 1'b1;
          counter_value_r <= counter_value_r - 16'h0001;
        end else if (down_r && at_bottom) begin
          down_r          <= 1'b0;
          counter_value_r <= counter_value_r + 16'h0001;
        end else begin
          counter_value_r <= down_r ? counter_value_r - 16'h0001 : counter_value_r + 16'h0001;
        end
      end else begin
        down_r          <= 1'b0;
        counter_value_r <= at_top ? 16'h0000 : counter_value_r + 16'h0001;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // compare channels: comparators, buffers, waveform outputs
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : chan
      assign match[g] = tick && counter_value_r == channel_compare_value_r[g];

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          channel_compare_value_r[g]  <= 16'h0000;
          channel_compare_buffer_r[g] <= 16'h0000;
        end else if (reset_cmd) begin
          channel_compare_value_r[g]  <= 16'h0000;
          channel_compare_buffer_r[g] <= 16'h0000;
        end else begin
          if (wr_en && paddr == `OFF_CMPBUF0 + 4 * g)
            channel_compare_buffer_r[g] <= pwdata[15:0];
          if (wr_en && paddr == `OFF_CMP0 + 4 * g)
            channel_compare_value_r[g] <= pwdata[15:0];   // direct write bypasses buffer
          else if (do_update)
            channel_compare_value_r[g] <= channel_compare_buffer_r[g];
        end
      end

      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          waveform_output_r[g] <= 1'b0;
        end else if (reset_cmd || restart_cmd) begin
          waveform_output_r[g] <= 1'b0;
        end else if (!timer_on) begin
          waveform_output_r[g] <= forced_output_value_r[g];
        end else if (tick) begin
          case (waveform_mode_select_r)
            `WM_FREQ:
              if (match[g]) waveform_output_r[g] <= ~waveform_output_r[g];
            `WM_SINGLE:
              if (at_top) waveform_output_r[g] <= 1'b0;
              else if (match[g]) waveform_output_r[g] <= 1'b1;
            `WM_DSTOP, `WM_DSBOTH, `WM_DSBOTTOM:
              if (at_bottom) waveform_output_r[g] <= 1'b1;
              else if (match[g]) waveform_output_r[g] <= down_r;
            default:
              waveform_output_r[g] <= waveform_output_r[g];
          endcase
        end
      end

      // port override, invert applies to the timer's waveform only
      always @(posedge pclk or negedge presetn) begin
        if (!presetn)
          pin_out[g] <= 1'b0;
        else if (channel_output_enable_r[g] && waveform_mode_select_r != `WM_NORMAL && !event_action_on[g])
          pin_out[g] <= waveform_output_r[g] ^ pin_invert_enable_r[g];
        else
          pin_out[g] <= port_out_latch[g];
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // flags: set wins over clear; match flag lands one tick after the match
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      match_pend_r              <= 4'h0;
      ovf_pend_r                <= 1'b0;
      channel_match_flag_r      <= 4'h0;
      overflow_underflow_flag_r <= 1'b0;
      capture_error_flag_r      <= 1'b0;
    end else if (reset_cmd) begin
      match_pend_r              <= 4'h0;
      ovf_pend_r                <= 1'b0;
      channel_match_flag_r      <= 4'h0;
      overflow_underflow_flag_r <= 1'b0;
      capture_error_flag_r      <= 1'b0;
    end else begin
      if (tick) begin
        match_pend_r <= match;
        ovf_pend_r   <= ovf_cond;
      end
      channel_match_flag_r <= (channel_match_flag_r &
                               ~(dma_ack_ch | ((wr_en && paddr == `OFF_FLAGS) ? pwdata[7:4] : 4'h0)))
                              | ((tick) ? match_pend_r : 4'h0);
      overflow_underflow_flag_r <= (overflow_underflow_flag_r &
                                    ~(dma_ack_ovf | (wr_en && paddr == `OFF_FLAGS && pwdata[`FLAG_OVF])))
                                   | (tick & ovf_pend_r);
      // no capture path here, so the error flag only clears
      if (wr_en && paddr == `OFF_FLAGS && pwdata[`FLAG_ERR])
        capture_error_flag_r <= 1'b0;
    end
  end

  assign match_event = tick ? match_pend_r : 4'h0;
  assign ovf_event   = tick & ovf_pend_r;
  assign dma_req_ovf = overflow_underflow_flag_r;
  assign dma_req_ch  = channel_match_flag_r;

  //////////////////////////////////////////////////////////////////////////
  // control registers and period buffering
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clock_source_select_r   <= `RST_CLKCTRL;
      waveform_mode_select_r  <= 3'h0;
      channel_output_enable_r <= 4'h0;
      forced_output_value_r   <= `RST_FORCECTRL;
      pin_invert_enable_r     <= 4'h0;
      lock_update_r           <= 1'b0;
      period_value_r          <= `RST_PERIOD;
      period_buffer_r         <= `RST_PERIOD;
    end else if (reset_cmd) begin
      clock_source_select_r   <= `RST_CLKCTRL;
      waveform_mode_select_r  <= 3'h0;
      channel_output_enable_r <= 4'h0;
      forced_output_value_r   <= `RST_FORCECTRL;
      pin_invert_enable_r     <= 4'h0;
      lock_update_r           <= 1'b0;
      period_value_r          <= `RST_PERIOD;
      period_buffer_r         <= `RST_PERIOD;
    end else begin
      if (wr_en && paddr == `OFF_CLKCTRL)
        clock_source_select_r <= pwdata[3:0];
      if (wr_en && paddr == `OFF_MODECTRL) begin
        waveform_mode_select_r  <= pwdata[2:0];
        channel_output_enable_r <= pwdata[7:4];
      end
      if (wr_en && paddr == `OFF_FORCECTRL)
        forced_output_value_r <= pwdata[3:0];
      if (wr_en && paddr == `OFF_INVCTRL)
        pin_invert_enable_r <= pwdata[3:0];
      if (wr_en && paddr == `OFF_CMDCTRL)
        lock_update_r <= pwdata[`CMD_LOCK];
      if (wr_en && paddr == `OFF_PERIOD_BUFFER)
        period_buffer_r <= pwdata[15:0];
      if (wr_en && paddr == `OFF_PERIOD)
        period_value_r <= pwdata[15:0];
      else if (do_update)
        period_value_r <= period_buffer_r;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // read data, captured in the setup phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_en) begin
      case (paddr)
        `OFF_CLKCTRL:   prdata <= {28'h0000000, clock_source_select_r};
        `OFF_MODECTRL:  prdata <= {24'h000000, channel_output_enable_r, 1'b0, waveform_mode_select_r};
        `OFF_FORCECTRL: prdata <= {28'h0000000, waveform_output_r};
        `OFF_CMDCTRL:   prdata <= {28'h0000000, lock_update_r, 3'h0};
        `OFF_FLAGS:     prdata <= {24'h000000, channel_match_flag_r, 2'h0, capture_error_flag_r,
                                   overflow_underflow_flag_r};
        `OFF_INVCTRL:   prdata <= {28'h0000000, pin_invert_enable_r};
        `OFF_COUNTER:   prdata <= {16'h0000, counter_value_r};
        `OFF_PERIOD:    prdata <= {16'h0000, period_value_r};
        `OFF_PERIOD_BUFFER:    prdata <= {16'h0000, period_buffer_r};
        `OFF_CMP0:                prdata <= {16'h0000, channel_compare_value_r[0]};
        `OFF_CMP0 + 12'h004:      prdata <= {16'h0000, channel_compare_value_r[1]};
        `OFF_CMP0 + 12'h008:      prdata <= {16'h0000, channel_compare_value_r[2]};
        `OFF_CMP0 + 12'h00c:      prdata <= {16'h0000, channel_compare_value_r[3]};
        `OFF_CMPBUF0:             prdata <= {16'h0000, channel_compare_buffer_r[0]};
        `OFF_CMPBUF0 + 12'h004:   prdata <= {16'h0000, channel_compare_buffer_r[1]};
        `OFF_CMPBUF0 + 12'h008:   prdata <= {16'h0000, channel_compare_buffer_r[2]};
        `OFF_CMPBUF0 + 12'h00c:   prdata <= {16'h0000, channel_compare_buffer_r[3]};
        default:        prdata <= 32'h00000000;
      endcase
    end
  end

endmodule

// ### verif/tcwave_sva.sv
/* checker for the timer compare waveform unit: flag, event, dma and pin relations.
   assumes: bound to the unit's ports; control writes are shadowed here from apb. */
`timescale 1ns/1ps
module tcwave_sva (
  // apb
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [31:0] prdata,
  // flags, events, dma
  input wire        ovf_event,
  input wire [3:0]  match_event,
  input wire        dma_ack_ovf,
  input wire [3:0]  dma_ack_ch,
  input wire        dma_req_ovf,
  input wire [3:0]  dma_req_ch,
  // port
  input wire [3:0]  port_out_latch,
  input wire [3:0]  event_action_on,
  input wire [3:0]  pin_out
);
  reg  [3:0] clk_s;
  reg  [7:0] mode_s;
  wire       wr      = psel && penable && pwrite;
  wire       flag_wr = wr && (paddr == 12'h010 || paddr == 12'h00c);
  // channel 0 overridden in any mode but normal, reserved codes included, with its enable and no event action
  wire       ovr0    = (mode_s[2:0] != 3'h0) && mode_s[4] && !event_action_on[0];

  // shadow of clock select and mode; a reset command only counts with the clock off
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_s  <= 4'h0;
      mode_s <= 8'h00;
    end else if (wr && paddr == 12'h00c && pwdata[2] && clk_s == 4'h0) begin
      clk_s  <= 4'h0;
      mode_s <= 8'h00;
    end else if (wr && paddr == 12'h000) begin
      clk_s  <= pwdata[3:0];
    end else if (wr && paddr == 12'h004) begin
      mode_s <= pwdata[7:0];
    end
  end

  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  //////////////////////////////////////////////////////////////////////////////
  a_read_upper_zero :
    assert property (psel && penable && !pwrite && paddr == 12'h000 |-> prdata[31:4] == 28'h0)
    else $error("clock select upper bits read nonzero");
  a_ovf_event_rise :
    assert property ($rose(dma_req_ovf) |-> $past(ovf_event))
    else $error("overflow flag set without event");
  a_match_event_rise :
    assert property ($rose(dma_req_ch[0]) |-> $past(match_event[0]))
    else $error("match flag set without event");
  a_ovf_ack_clear :
    assert property (dma_ack_ovf |=> !dma_req_ovf || $past(ovf_event))
    else $error("overflow request not cleared by ack");
  a_ch_ack_clear :
    assert property (dma_ack_ch[0] |=> !dma_req_ch[0] || $past(match_event[0]))
    else $error("match request not cleared by ack");
  a_event_has_flag :
    assert property (match_event[1] |=> dma_req_ch[1])
    else $error("match event without flag");
  a_flag_sticky :
    assert property (dma_req_ch[0] && !dma_ack_ch[0] && !flag_wr |=> dma_req_ch[0])
    else $error("match flag dropped by itself");
  a_pin_passthru :
    assert property (!ovr0 |=> pin_out[0] == $past(port_out_latch[0]))
    else $error("pin not showing latch without override");

  c_ovf     : cover property (ovf_event);
  c_match   : cover property (match_event[0]);
  c_pin_ovr : cover property (ovr0 ##1 $rose(pin_out[0]));
endmodule

bind timer_compare_waveform_unit tcwave_sva u_sva (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .ovf_event(ovf_event),
  .match_event(match_event), .dma_ack_ovf(dma_ack_ovf), .dma_ack_ch(dma_ack_ch),
  .dma_req_ovf(dma_req_ovf), .dma_req_ch(dma_req_ch), .port_out_latch(port_out_latch),
  .event_action_on(event_action_on), .pin_out(pin_out)
);

// ### verif/port_pins_model.sv
/* port pin model: output latch register and the load watching pin 0.
   assumes: latch contents set by the bench; all four pins are outputs. */
`timescale 1ns/1ps
module port_pins_model (
  // clock and reset
  input wire        pclk,
  input wire        presetn,
  // pin side
  input wire [3:0]  pin_out,
  input wire [3:0]  latch_set,
  output reg [3:0]  port_out_latch,
  output reg [15:0] toggles
);
  reg p0_r;

  // direction fixed as output, so an override on pin 0 shows on the load
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_out_latch <= 4'h0;
      p0_r           <= 1'b0;
      toggles        <= 16'h0;
    end else begin
      port_out_latch <= latch_set;
      p0_r           <= pin_out[0];
      if (pin_out[0] != p0_r) begin
        toggles <= toggles + 16'h1;
      end
    end
  end
endmodule

// ### verif/test_timer_compare_waveform_unit.sv
/* bench for the timer compare waveform unit: apb tasks and directed tests.
   assumes: zero wait apb slave; pins loaded by the port model. */
`timescale 1ns/1ps
module test_timer_compare_waveform_unit;
  reg         pclk, presetn, psel, penable, pwrite, dma_ack_ovf;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rv;
  reg  [7:0]  event_in;
  reg  [3:0]  dma_ack_ch, event_action_on, latch_set;
  wire [31:0] prdata;
  wire        pready, pslverr, ovf_event, dma_req_ovf;
  wire [3:0]  match_event, dma_req_ch, port_out_latch, pin_out;
  wire [15:0] toggles;
  integer     n_fail, checks, cyc;

  always #25 pclk = ~pclk;

  timer_compare_waveform_unit dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .event_in(event_in), .ovf_event(ovf_event), .match_event(match_event),
    .dma_ack_ovf(dma_ack_ovf), .dma_ack_ch(dma_ack_ch), .dma_req_ovf(dma_req_ovf),
    .dma_req_ch(dma_req_ch), .port_out_latch(port_out_latch),
    .event_action_on(event_action_on), .pin_out(pin_out));
  port_pins_model pins (.pclk(pclk), .presetn(presetn), .pin_out(pin_out),
    .latch_set(latch_set), .port_out_latch(port_out_latch), .toggles(toggles));

  //////////////////////////////////////////////////////////////////////////////
  task chk(input [31:0] got, input [31:0] exp);
    begin
      checks = checks + 1;
      if (got !== exp) begin
        n_fail = n_fail + 1;
        $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask

  // one transfer; request held until pready is seen high
  task apb(input w, input [11:0] a, input [31:0] d);
    begin
      @(posedge pclk);
      psel    <= 1'b1;
      pwrite  <= w;
      paddr   <= a;
      pwdata  <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rv = prdata;
      psel    <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  task rdchk(input [11:0] a, input [31:0] e);
    begin
      apb(1'b0, a, 32'h0);
      chk(rv, e);
    end
  endtask

  task settle;
    begin
      repeat (3) @(posedge pclk);
      @(negedge pclk);
    end
  endtask

  // stop, load counter, period, compare and their buffers, then start
  task cfg(input [7:0] md, input [15:0] period_value, input [15:0] cmp, input [3:0] cs);
    begin
      apb(1'b1, 12'h000, 32'h0);
      apb(1'b1, 12'h020, 32'h0);
      apb(1'b1, 12'h024, {16'h0, period_value});
      apb(1'b1, 12'h028, {16'h0, period_value});
      apb(1'b1, 12'h030, {16'h0, cmp});
      apb(1'b1, 12'h040, {16'h0, cmp});
      apb(1'b1, 12'h004, {24'h0, md});
      apb(1'b1, 12'h000, {28'h0, cs});
      repeat (16) @(posedge pclk);
    end
  endtask

  // pin 0 toggles and overflow events over n whole cycles
  task meas(input integer n, input integer etog, input integer eovf);
    integer     o;
    reg  [15:0] t0;
    begin
      o = 0;
      @(negedge pclk);
      t0 = toggles;
      repeat (n) begin
        @(negedge pclk);
        if (ovf_event === 1'b1) o = o + 1;
      end
      chk({16'h0, toggles - t0}, etog);
      chk(o, eovf);
    end
  endtask

  task summarize;
    begin
      $display("checks=%0d n_fail=%0d", checks, n_fail);
      if (n_fail == 0 && checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask

  // hang guard
  always @(posedge pclk) begin
    cyc = cyc + 1;
    if (cyc == 20000) begin
      n_fail = n_fail + 1;
      summarize;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    {pclk, presetn, psel, penable, pwrite, dma_ack_ovf} = 6'h0;
    {paddr, pwdata, event_in, dma_ack_ch, event_action_on} = 60'h0;
    latch_set = 4'ha;
    n_fail = 0;
    checks = 0;
    cyc = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(12'h000, 32'h0);
    rdchk(12'h024, 32'hffff);
    apb(1'b1, 12'h000, 32'h0f);
    rdchk(12'h000, 32'h0f);
    rdchk(12'hffc, 32'h0);
    $display("done registers");
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h004, 32'h13);
    apb(1'b1, 12'h008, 32'h1);
    settle;
    chk(pin_out, 4'hb);
    rdchk(12'h008, 32'h1);
    event_action_on <= 4'h1;
    settle;
    chk(pin_out, 4'ha);
    @(posedge pclk);
    event_action_on <= 4'h0;
    apb(1'b1, 12'h014, 32'h1);
    settle;
    chk(pin_out, 4'ha);
    apb(1'b1, 12'h014, 32'h0);
    $display("done port override");
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h00c, 32'h4);
    rdchk(12'h004, 32'h13);
    apb(1'b1, 12'h000, 32'h0);
    apb(1'b1, 12'h00c, 32'h4);
    rdchk(12'h004, 32'h0);
    apb(1'b1, 12'h000, 32'h8);
    apb(1'b1, 12'h020, 32'h1234);
    rdchk(12'h020, 32'h1234);
    apb(1'b1, 12'h00c, 32'h2);
    rdchk(12'h020, 32'h0);
    apb(1'b1, 12'h040, 32'h55);
    rdchk(12'h030, 32'h0);
    apb(1'b1, 12'h00c, 32'h8);
    apb(1'b1, 12'h00c, 32'h9);
    rdchk(12'h030, 32'h0);
    apb(1'b1, 12'h00c, 32'h0);
    apb(1'b1, 12'h00c, 32'h1);
    rdchk(12'h030, 32'h55);
    apb(1'b1, 12'h000, 32'hb);
    repeat (5) begin
      @(posedge pclk);
      event_in <= 8'h08;
      @(posedge pclk);
      event_in <= 8'h00;
    end
    repeat (2) @(posedge pclk);
    rdchk(12'h020, 32'h5);
    $display("done commands");
    cfg(8'h11, 16'hffff, 16'h0, 4'h1);
    meas(20, 20, 20);
    cfg(8'h11, 16'hffff, 16'h0, 4'h2);
    meas(20, 10, 10);
    cfg(8'h11, 16'hffff, 16'h2, 4'h1);
    meas(30, 10, 10);
    cfg(8'h13, 16'h3, 16'h1, 4'h1);
    meas(40, 20, 10);
    cfg(8'h15, 16'h4, 16'h2, 4'h1);
    meas(40, 10, 5);
    cfg(8'h16, 16'h4, 16'h2, 4'h1);
    meas(40, 10, 10);
    cfg(8'h17, 16'h4, 16'h2, 4'h1);
    meas(40, 10, 5);
    $display("done waveforms");
    apb(1'b1, 12'h000, 32'h0);
    @(negedge pclk);
    chk({31'h0, dma_req_ovf}, 32'h1);
    chk({31'h0, dma_req_ch[0]}, 32'h1);
    @(posedge pclk);
    dma_ack_ovf <= 1'b1;
    dma_ack_ch  <= 4'h1;
    @(posedge pclk);
    dma_ack_ovf <= 1'b0;
    dma_ack_ch  <= 4'h0;
    @(negedge pclk);
    chk({31'h0, dma_req_ovf}, 32'h0);
    chk({31'h0, dma_req_ch[0]}, 32'h0);
    apb(1'b1, 12'h010, 32'hff);
    rdchk(12'h010, 32'h0);
    $display("done flags");
    summarize;
  end
endmodule
